// ===== bench/low_power_wakeup_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module low_power_wakeup_control_tb;
    import lpwc_pkg::*;
    localparam int CPM = 4;
    logic          ref_clk = 1'b0;
    logic          srst = 1'b1;
    logic          ce = 1'b1;
    logic [5:0]    wake_in = 6'h00;
    logic [2:0]    ev = 3'h0;
    logic          supply_low = 1'b0;
    logic          reset_done = 1'b0;
    logic          reg_wr, reg_rd, wake_irq, hs1_on, hs2_on, lvf, erf;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata, d, r;
    logic [3:0]    c;
    logic [1:0]    s;
    lpwc_mode_type mode_state;
    logic [31:0]   seed = 32'h7866f427;
    int n_errors = 0, checks_done = 0, cyc = 0, last = 0, gap = 0, f, t0, j, a, b;
    int n_irq = 0, n_hs1 = 0, n_hs2 = 0, n_hs = 0, n_lvf = 0, n_erf = 0;
    int fw[6] = '{1, 2, 3, 4, 11, 13};
    lpwc_top #(.CYCLES_PER_MS(CPM)) dut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .wake_in(wake_in), .bus_wake(ev[0]),
        .lvr_evt(ev[1]), .ext_rst_evt(ev[2]), .supply_low(supply_low), .reset_done(reset_done),
        .reg_rdata(reg_rdata), .mode_state(mode_state), .wake_irq(wake_irq), .hs1_on(hs1_on), .hs2_on(hs2_on),
        .core_supply_low_voltage_flag(lvf), .external_reset_flag(erf));
    lpwc_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc   <= cyc + 1;
        n_irq <= n_irq + int'(wake_irq === 1'b1);
        n_hs1 <= n_hs1 + int'(hs1_on === 1'b1);
        n_hs2 <= n_hs2 + int'(hs2_on === 1'b1);
        n_lvf <= n_lvf + int'(lvf === 1'b1);
        n_erf <= n_erf + int'(erf === 1'b1);
        if (hs1_on === 1'b1 || hs2_on === 1'b1) begin
            gap  <= cyc - last;
            last <= cyc;
            n_hs <= n_hs + 1;
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int ms_of(input logic [3:0] k);
        int t[10] = '{1, 2, 5, 10, 20, 50, 100, 200, 500, 1000};
        return (k > 4'h9) ? 1000 : t[k];
    endfunction
    task automatic wait_mode(input lpwc_mode_type m, input int n);
        for (int i = 0; i < n && mode_state !== m; i++) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk_mode(input lpwc_mode_type m, input int n);
        wait_mode(m, n);
        `CHK(mode_state, m)
    endtask
    task automatic src(input logic [7:0] e);
        host.rd(8'h14, d);
        `CHK(d, e)
    endtask
    task automatic kick(input int k);
        @(posedge ref_clk);
        ev <= 3'(1 << k);
        @(posedge ref_clk);
        ev <= 3'h0;
        #1;
    endtask
    task automatic flip(input int i);
        @(posedge ref_clk);
        wake_in <= wake_in ^ (6'h01 << i);
        #1;
    endtask
    task automatic rst_done();
        @(posedge ref_clk);
        reset_done <= 1'b1;
        chk_mode(LPWC_NORMAL, 4);
        @(posedge ref_clk);
        reset_done <= 1'b0;
        host.rd(8'h14, d);
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        host.rd(8'h12, d);
        `CHK(d, 8'h3f)
        host.rd(8'h13, d);
        `CHK(d, 8'h00)
        host.wr(8'h14, 8'hff);
        src(8'h00);
        repeat (4) begin
            r = 8'(rnd());
            host.wr(8'h12, r);
            host.rd(8'h12, d);
            `CHK(d, r)
        end
        host.wr(8'h12, 8'h3f);
        host.wr(8'h11, 8'h01);
        chk_mode(LPWC_STOP, 2);
        host.rd(8'h11, d);
        `CHK(d, 8'(LPWC_STOP))
        host.wr(8'h11, 8'h00);
        chk_mode(LPWC_NORMAL, 2);
        src(8'h00);
        for (int i = 0; i < 6; i++) begin
            j = (i + 1) % 6;
            host.wr(8'h12, {2'b00, ~(6'h01 << j)});
            host.wr(8'h11, 8'h01);
            a = n_irq;
            flip(j);
            wait_mode(LPWC_NORMAL, 10);
            `CHK(mode_state, LPWC_STOP)
            flip(i);
            chk_mode(LPWC_NORMAL, 8);
            src(8'(1 << i));
            src(8'h00);
            `CHK(n_irq, a + 1)
        end
        host.wr(8'h12, 8'h3f);
        host.wr(8'h11, 8'h01);
        @(posedge ref_clk);
        ce <= 1'b0;
        kick(0);
        `CHK(mode_state, LPWC_STOP)
        @(posedge ref_clk);
        ce <= 1'b1;
        kick(0);
        chk_mode(LPWC_NORMAL, 4);
        host.wr(8'h11, 8'h01);
        wait_mode(LPWC_STOP, 4);
        `CHK(mode_state, LPWC_NORMAL)
        src(8'h40);
        host.wr(8'h11, 8'h01);
        chk_mode(LPWC_STOP, 2);
        host.wr(8'h11, 8'h00);
        src(8'h00);
        host.wr(8'h12, 8'h7f);
        host.wr(8'h13, 8'h03);
        host.wr(8'h11, 8'h01);
        n_hs = 0;
        for (int w = 0; w < 200 && n_hs < 2; w++) @(posedge ref_clk);
        repeat (5) @(posedge ref_clk);
        flip(0);
        repeat (5) @(posedge ref_clk);
        flip(0);
        wait_mode(LPWC_NORMAL, 100);
        `CHK(mode_state, LPWC_STOP)
        flip(0);
        chk_mode(LPWC_NORMAL, 100);
        src(8'h01);
        for (int k = 0; k < 6; k++) begin
            c = 4'(fw[k]);
            f = 1 << ((c > 4'hb ? 11 : int'(c)) - 1);
            s = 2'(fw[k] % 4);
            host.wr(8'h12, {s, 5'h00, k == 0});
            host.wr(8'h13, {c, 4'h0});
            host.wr(8'h11, 8'h01);
            t0 = cyc;
            n_hs1 = 0;
            n_hs2 = 0;
            if (k == 0) flip(0);
            chk_mode(LPWC_NORMAL, f * CPM + 8);
            `CHK(cyc - t0 inside {[f * CPM - 2 : f * CPM + 4]}, 1'b1)
            `CHK(n_hs1 - f * int'(s[0]) inside {[-1 : 1]}, 1'b1)
            `CHK(n_hs2 - f * int'(s[1]) inside {[-1 : 1]}, 1'b1)
            src(8'h80);
        end
        for (int k = 0; k < 8; k++) begin
            c = (k == 7) ? 4'ha : 4'(k);
            s = 2'(1 + k % 3);
            host.wr(8'h12, {s, 6'h00});
            host.wr(8'h13, {4'h0, c});
            host.wr(8'h11, 8'h01);
            n_hs = 0;
            n_hs1 = 0;
            n_hs2 = 0;
            for (int w = 0; w < 13000 && n_hs < 3; w++) begin
                @(posedge ref_clk);
                wake_in <= 6'(rnd());
            end
            #1;
            `CHK(gap, ms_of(c) * CPM)
            `CHK(n_hs1 == 0, !s[0])
            `CHK(n_hs2 == 0, !s[1])
            `CHK(mode_state, LPWC_STOP)
            host.wr(8'h11, 8'h00);
            src(8'h00);
        end
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        host.rd(8'h12, d);
        `CHK(d, 8'h3f)
        host.rd(8'h13, d);
        `CHK(d, 8'h00)
        for (int k = 1; k < 3; k++) begin
            host.wr(8'h11, 8'h01);
            a = n_lvf;
            b = n_erf;
            kick(k);
            chk_mode(LPWC_RESET, 4);
            repeat (2) @(posedge ref_clk);
            `CHK(n_lvf, a + int'(k == 1))
            `CHK(n_erf, b + int'(k == 2))
            rst_done();
        end
        host.wr(8'h11, 8'h02);
        chk_mode(LPWC_SLEEP, 2);
        @(posedge ref_clk);
        supply_low <= 1'b1;
        chk_mode(LPWC_POWER_ON, 4);
        @(posedge ref_clk);
        supply_low <= 1'b0;
        rst_done();
        host.wr(8'h11, 8'h02);
        kick(0);
        chk_mode(LPWC_RESET, 4);
        @(posedge ref_clk);
        reset_done <= 1'b1;
        chk_mode(LPWC_NORMAL, 4);
        @(posedge ref_clk);
        reset_done <= 1'b0;
        src(8'h40);
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== bench/lpwc_host.sv
`timescale 1ns/1ps
`default_nettype none
module lpwc_host (
    input  wire logic       ref_clk,   // base clock
    output logic            reg_wr,    // write strobe
    output logic            reg_rd,    // read strobe
    output logic [7:0]      reg_addr,  // register offset
    output logic [7:0]      reg_wdata, // write data
    input  wire logic [7:0] reg_rdata  // read data
);
    int cyc    = 0;
    int src_rd = -9;
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        while (a == 8'h11 && cyc - src_rd < 3) @(posedge ref_clk);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rdata;
        if (a == 8'h14) src_rd = cyc;
    endtask
endmodule
`default_nettype wire

// ===== rtl/lpwc_params.svh
`ifndef LPWC_PARAMS_SVH
`define LPWC_PARAMS_SVH
`define LPWC_OFS_MODE      8'h11
`define LPWC_OFS_WAKE_CTL  8'h12
`define LPWC_OFS_WAKE_TIM  8'h13
`define LPWC_OFS_WAKE_SRC  8'h14
`define LPWC_RST_WAKE_CTL  8'h3f
`define LPWC_RST_WAKE_TIM  8'h00
`define LPWC_RST_WAKE_SRC  8'h00
`define LPWC_CYCLIC_SENSE_SELECT_MSB     7
`define LPWC_CYCLIC_SENSE_SELECT_LSB     6
`define LPWC_FWM_MSB       7
`define LPWC_FWM_LSB       4
`define LPWC_CST_MSB       3
`define LPWC_CST_LSB       0
`define LPWC_FWU_BIT       7
`define LPWC_BUSWU_BIT     6
`define LPWC_MODE_NORMAL   2'h0
`define LPWC_MODE_STOP     2'h1
`define LPWC_MODE_SLEEP    2'h2
`define LPWC_MS_NS         1000000
`define LPWC_CLK_NS        100
`endif

// ===== rtl/lpwc_pkg.sv
package lpwc_pkg;
    typedef enum logic [2:0] {
        LPWC_NORMAL,
        LPWC_STOP,
        LPWC_SLEEP,
        LPWC_RESET,
        LPWC_POWER_ON
    } lpwc_mode_type;
endpackage

// ===== rtl/lpwc_top.sv
// How it works
// - stop exits on host normal-mode write
// - host-request wake sets no source flag
// - stop: low-voltage/external reset enters reset mode
// - sleep: supply below threshold enters power-on
// - wake control layout; reset 0x3f
// - select codes pick high-side outputs
// - no enables: still switch, detect no input change
// - forced wake runs with any select
// - enable bit arms its input
// - multiplier field; zero disables forced wake
// - codes double 1x to 1024x; 11xx=1024x
// - period field: 1 ms up to 1000 ms
// - source flags: forced, bus, inputs
// - armed input change sets its flag
// - source read clears; writes ignored
// - stop refused until source read after wake
// - cyclic mode compares sample to sample
// - forced plus input reports forced only
// - stop wake: irq, normal; sleep: reset
`timescale 1ns/1ps
`default_nettype none
`include "lpwc_params.svh"
module lpwc_top #(
    parameter int unsigned CYCLES_PER_MS = `LPWC_MS_NS / `LPWC_CLK_NS
) (
    input  wire logic                   ref_clk,       // base clock
    input  wire logic                   srst,          // sync reset
    input  wire logic                   ce,            // clock enable
    input  wire logic                   reg_wr,        // link write strobe
    input  wire logic                   reg_rd,        // link read strobe
    input  wire logic [7:0]             reg_addr,      // register offset
    input  wire logic [7:0]             reg_wdata,     // write data
    input  wire logic [5:0]             wake_in,       // wake input levels
    input  wire logic                   bus_wake,      // bus wake pulse
    input  wire logic                   lvr_evt,       // core low voltage
    input  wire logic                   ext_rst_evt,   // external reset
    input  wire logic                   supply_low,    // supply below threshold
    input  wire logic                   reset_done,    // reset/power-on over
    output logic [7:0]                  reg_rdata,     // read data
    output lpwc_pkg::lpwc_mode_type     mode_state,    // current mode
    output logic                        wake_irq,      // stop wake pulse
    output logic                        hs1_on,        // high side one
    output logic                        hs2_on,        // high side two
    output logic                        core_supply_low_voltage_flag, // pulse
    output logic                        external_reset_flag           // pulse
);
    import lpwc_pkg::*;

    function automatic logic [9:0] period_ms(input logic [3:0] code);
        case (code)
            4'h0: period_ms = 10'd1;
            4'h1: period_ms = 10'd2;
            4'h2: period_ms = 10'd5;
            4'h3: period_ms = 10'd10;
            4'h4: period_ms = 10'd20;
            4'h5: period_ms = 10'd50;
            4'h6: period_ms = 10'd100;
            4'h7: period_ms = 10'd200;
            4'h8: period_ms = 10'd500;
            default: period_ms = 10'd1000;
        endcase
    endfunction

    function automatic logic [10:0] mult(input logic [3:0] code);
        if (code == 4'h0) begin
            mult = 11'h0;
        end else if (code >= 4'hb) begin
            mult = 11'h400;
        end else begin
            mult = 11'h1 << (code - 4'h1);
        end
    endfunction

    lpwc_mode_type mode_q;
    logic [7:0]    wake_ctl_q;
    logic [7:0]    wake_tim_q;
    logic [7:0]    wake_src_q;
    logic [7:0]    rdata_q;
    logic          src_read_q;
    logic          irq_q;
    logic          hs1_q;
    logic          hs2_q;
    logic          lvr_q;
    logic          exr_q;
    logic [5:0]    sync1_q;
    logic [5:0]    sync2_q;
    logic [5:0]    ref_q;
    logic [31:0]   ms_cnt_q;
    logic [9:0]    cs_cnt_q;
    logic [10:0]   fw_cnt_q;

    logic          low_pwr;
    logic          ms_tick;
    logic          cs_evt;
    logic          fw_evt;
    logic [1:0]    cs_sel;
    logic [5:0]    change;
    logic [7:0]    wake_set;
    logic          wake_evt;
    logic          wr_mode;
    logic          rd_src;

    assign low_pwr  = (mode_q == LPWC_STOP) || (mode_q == LPWC_SLEEP);
    assign cs_sel   = wake_ctl_q[`LPWC_CYCLIC_SENSE_SELECT_MSB:`LPWC_CYCLIC_SENSE_SELECT_LSB];
    assign ms_tick  = low_pwr && (ms_cnt_q == CYCLES_PER_MS - 1);
    assign cs_evt   = ms_tick &&
                      (cs_cnt_q == period_ms(wake_tim_q[`LPWC_CST_MSB:`LPWC_CST_LSB]) - 10'd1);
    assign fw_evt   = cs_evt && (mult(wake_tim_q[`LPWC_FWM_MSB:`LPWC_FWM_LSB]) != 11'h0) &&
                      (fw_cnt_q == mult(wake_tim_q[`LPWC_FWM_MSB:`LPWC_FWM_LSB]) - 11'h1);
    assign wr_mode  = reg_wr && (reg_addr == `LPWC_OFS_MODE);
    assign rd_src   = reg_rd && (reg_addr == `LPWC_OFS_WAKE_SRC);

    always_comb begin
        change = 6'h0;
        if (low_pwr && ((cs_sel == 2'b00) || cs_evt)) begin
            change = (sync2_q ^ ref_q) & wake_ctl_q[5:0];
        end
    end

    always_comb begin
        wake_set = 8'h0;
        if (low_pwr) begin
            if (fw_evt) begin
                wake_set[`LPWC_FWU_BIT] = 1'b1;
            end else begin
                wake_set[5:0] = change;
            end
            wake_set[`LPWC_BUSWU_BIT] = bus_wake;
        end
    end
    assign wake_evt = |wake_set;

    // input synchroniser and reference level
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_q <= 6'h0;
            sync2_q <= 6'h0;
            ref_q   <= 6'h0;
        end else if (ce) begin
            sync1_q <= wake_in;
            sync2_q <= sync1_q;
            if (!low_pwr || cs_sel == 2'b00 || cs_evt) begin
                ref_q <= sync2_q;
            end
        end
    end

    // sense and forced timers, idle outside low power
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ms_cnt_q <= 32'h0;
            cs_cnt_q <= 10'h0;
            fw_cnt_q <= 11'h0;
        end else if (ce) begin
            if (!low_pwr) begin
                ms_cnt_q <= 32'h0;
                cs_cnt_q <= 10'h0;
                fw_cnt_q <= 11'h0;
            end else if (ms_tick) begin
                ms_cnt_q <= 32'h0;
                if (cs_evt) begin
                    cs_cnt_q <= 10'h0;
                    fw_cnt_q <= fw_evt ? 11'h0 : fw_cnt_q + 11'h1;
                end else begin
                    cs_cnt_q <= cs_cnt_q + 10'h1;
                end
            end else begin
                ms_cnt_q <= ms_cnt_q + 32'h1;
            end
        end
    end

    // selected high-side strobes at each sense event
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hs1_q <= 1'b0;
            hs2_q <= 1'b0;
        end else if (ce) begin
            hs1_q <= cs_evt && cs_sel[0];
            hs2_q <= cs_evt && cs_sel[1];
        end
    end

    // register writes; source register ignores writes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wake_ctl_q <= `LPWC_RST_WAKE_CTL;
            wake_tim_q <= `LPWC_RST_WAKE_TIM;
        end else if (ce && reg_wr) begin
            if (reg_addr == `LPWC_OFS_WAKE_CTL) begin
                wake_ctl_q <= reg_wdata;
            end
            if (reg_addr == `LPWC_OFS_WAKE_TIM) begin
                wake_tim_q <= reg_wdata;
            end
        end
    end

    // source flags: read clears, new set wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wake_src_q <= `LPWC_RST_WAKE_SRC;
        end else if (ce) begin
            wake_src_q <= (rd_src ? 8'h0 : wake_src_q) | wake_set;
        end
    end

    // read data
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_q <= 8'h0;
        end else if (ce && reg_rd) begin
            case (reg_addr)
                `LPWC_OFS_WAKE_CTL: rdata_q <= wake_ctl_q;
                `LPWC_OFS_WAKE_TIM: rdata_q <= wake_tim_q;
                `LPWC_OFS_WAKE_SRC: rdata_q <= wake_src_q;
                `LPWC_OFS_MODE:     rdata_q <= {5'h0, mode_q};
                default:            rdata_q <= 8'h0;
            endcase
        end
    end

    // stop permitted only after a source read since last wake
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            src_read_q <= 1'b1;
        end else if (ce) begin
            if (wake_evt || (mode_q == LPWC_STOP && wr_mode)) begin
                src_read_q <= 1'b0;
            end else if (rd_src) begin
                src_read_q <= 1'b1;
            end
        end
    end

    // mode sequencing
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_q <= LPWC_NORMAL;
            irq_q  <= 1'b0;
            lvr_q  <= 1'b0;
            exr_q  <= 1'b0;
        end else if (ce) begin
            irq_q <= 1'b0;
            lvr_q <= 1'b0;
            exr_q <= 1'b0;
            case (mode_q)
                LPWC_NORMAL: begin
                    if (wr_mode && reg_wdata[1:0] == `LPWC_MODE_STOP && src_read_q) begin
                        mode_q <= LPWC_STOP;
                    end else if (wr_mode && reg_wdata[1:0] == `LPWC_MODE_SLEEP) begin
                        mode_q <= LPWC_SLEEP;
                    end
                end
                LPWC_STOP: begin
                    if (lvr_evt || ext_rst_evt) begin
                        mode_q <= LPWC_RESET;
                        lvr_q  <= lvr_evt;
                        exr_q  <= ext_rst_evt;
                    end else if (wake_evt) begin
                        mode_q <= LPWC_NORMAL;
                        irq_q  <= 1'b1;
                    end else if (wr_mode && reg_wdata[1:0] == `LPWC_MODE_NORMAL) begin
                        mode_q <= LPWC_NORMAL;
                    end
                end
                LPWC_SLEEP: begin
                    if (supply_low) begin
                        mode_q <= LPWC_POWER_ON;
                    end else if (wake_evt) begin
                        mode_q <= LPWC_RESET;
                    end
                end
                LPWC_RESET, LPWC_POWER_ON: begin
                    if (reset_done) begin
                        mode_q <= LPWC_NORMAL;
                    end
                end
                default: mode_q <= LPWC_NORMAL;
            endcase
        end
    end

    assign reg_rdata                    = rdata_q;
    assign mode_state                   = mode_q;
    assign wake_irq                     = irq_q;
    assign hs1_on                       = hs1_q;
    assign hs2_on                       = hs2_q;
    assign core_supply_low_voltage_flag = lvr_q;
    assign external_reset_flag          = exr_q;

    stop_exit_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && mode_q == LPWC_STOP && wr_mode && reg_wdata[1:0] == `LPWC_MODE_NORMAL
        && !lvr_evt && !ext_rst_evt |=> mode_q == LPWC_NORMAL)
        else $error("stop not left on host request");
    host_noflag_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && mode_q == LPWC_STOP && wr_mode && !wake_evt && !rd_src
        |=> wake_src_q == $past(wake_src_q))
        else $error("host wake touched source flags");
    reset_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && mode_q == LPWC_STOP && lvr_evt
        |=> mode_q == LPWC_RESET && core_supply_low_voltage_flag)
        else $error("low voltage in stop not to reset");
    power_on_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && mode_q == LPWC_SLEEP && supply_low |=> mode_q == LPWC_POWER_ON)
        else $error("supply loss not to power on");
    ctl_reset_a: assert property (@(posedge ref_clk)
        $fell(srst) |-> wake_ctl_q == `LPWC_RST_WAKE_CTL && wake_tim_q == `LPWC_RST_WAKE_TIM)
        else $error("control reset value wrong");
    forced_prio_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && fw_evt && !rd_src |=> wake_src_q[7] && wake_src_q[5:0] == $past(wake_src_q[5:0]))
        else $error("forced wake not sole source");
    read_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && rd_src && !wake_evt |=> wake_src_q == 8'h0)
        else $error("source read did not clear");
    stop_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && mode_q == LPWC_NORMAL && !src_read_q && wr_mode
        && reg_wdata[1:0] == `LPWC_MODE_STOP |=> mode_q == LPWC_NORMAL)
        else $error("stop taken before source read");
    stop_irq_a: assert property (@(posedge ref_clk) disable iff (srst)
        wake_irq |-> mode_q == LPWC_NORMAL && $past(mode_q) == LPWC_STOP)
        else $error("irq without stop wake");
endmodule
`default_nettype wire
